// *** rtl/startup_supervisor.sv ***
// Start-up supervisor: reset line, confirmation timeout, wake, test mode
//
// Overview of operation
// - Low reset line holds the microcontroller in its start-up state.
// - Device pulls reset line low while any internal reset source runs.
// - Either side pulling the line low resets both dies.
// - Reset pin is open drain, driven and observed by this block.
// - Flag still clear at 80 ms expiry sends device to sleep.
// - Test select pin high puts the device in test mode.
// - Test mode stops the confirmation timer until the next reset release outside test mode.
// - Test mode disables the bus receiver output.
// - Wake input wakes the system on rising and falling edges.
// - Errors and wake events pull open-drain interrupt line low.
// - After supply rise reset is held low 0.8 to 1.94 ms.
// - Stop and sleep are chosen by two system control bits.
//
// Local design decisions: the Avalon-MM interface to the registers and the placing of the registers.
module startup_supervisor
  import supervisor_pkg::*;
#(
  parameter int HOLD_TICKS = RST_HOLD_US,
  parameter int CONF_TICKS = CONF_TIMEOUT_US
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [4:0]  i_avs_address,
  input  wire logic [31:0] i_avs_writedata,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic        i_rst_line_i,
  output logic             o_rst_line_o,
  output logic             o_rst_line_oe,
  output logic             o_irq_line_o,
  output logic             o_irq_line_oe,
  input  wire logic        i_wake_input_pin,
  input  wire logic        i_test_select_pin,
  input  wire logic        i_bus_rx,
  output logic             o_rx,
  output logic [2:0]       o_mode
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  if (HOLD_TICKS < 1 || HOLD_TICKS >= (1 << CNT_W)) begin : g_bad_hold
    $error("HOLD_TICKS out of range");
  end
  if (CONF_TICKS < 1 || CONF_TICKS >= (1 << CNT_W)) begin : g_bad_conf
    $error("CONF_TICKS out of range");
  end
  if (TICK_CYCLES < 2 || TICK_CYCLES > (1 << DIV_W)) begin : g_bad_div
    $error("TICK_CYCLES out of range");
  end

  localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_TICKS - 1);
  localparam logic [CNT_W-1:0] CONF_LAST = CNT_W'(CONF_TICKS - 1);
  localparam logic [DIV_W-1:0] DIV_LAST  = DIV_W'(TICK_CYCLES - 1);

  sup_state_t q_r;
  sup_state_t q_nxt;
  avs_req_t   req;
  logic       wake_edge;
  logic       line_rise;
  logic       bus_hit;

  assign req.read      = i_avs_read;
  assign req.write     = i_avs_write;
  assign req.address   = i_avs_address;
  assign req.writedata = i_avs_writedata;

  // ----------------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------------
  function automatic logic [31:0] read_mux(input sup_state_t s,
                                           input logic [4:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (a)
      ADDR_SYSCTL: begin
        d[SYSCTL_POWER_STAGE_ON_FLAG_BIT]  = s.power_stage_on_flag;
        d[SYSCTL_STOP_BIT]  = s.stop_req;
        d[SYSCTL_SLEEP_BIT] = s.sleep_req;
      end
      ADDR_STATUS: begin
        d[STATUS_MODE_LSB +: 3] = s.mode;
        d[STATUS_RUN_BIT]       = s.conf_run;
        d[STATUS_LINE_BIT]      = s.rl_s2;
        d[STATUS_TEST_BIT]      = s.tm_s2;
      end
      ADDR_IRQFLAG: begin
        d[FLAG_WAKE_BIT] = s.wake_flag;
        d[FLAG_TOUT_BIT] = s.tout_flag;
      end
      ADDR_IRQMASK: d[MASK_WAKE_BIT] = s.wake_en;
      default:      d = 32'h0000_0000;
    endcase
    return d;
  endfunction : read_mux

  assign wake_edge = q_r.wk_s2 ^ q_r.wk_s3;
  assign line_rise = q_r.rl_s2 & ~q_r.rl_s3;
  assign bus_hit   = (req.read | req.write) & ~q_r.waitreq;

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    q_nxt = q_r;

    // Pin synchronisers; first stages feed only the second stages
    q_nxt.tm_s1 = i_test_select_pin;
    q_nxt.tm_s2 = q_r.tm_s1;
    q_nxt.wk_s1 = i_wake_input_pin;
    q_nxt.wk_s2 = q_r.wk_s1;
    q_nxt.wk_s3 = q_r.wk_s2;
    q_nxt.rl_s1 = i_rst_line_i;
    q_nxt.rl_s2 = q_r.rl_s1;
    q_nxt.rl_s3 = q_r.rl_s2;
    q_nxt.rx_s1 = i_bus_rx;
    q_nxt.rx_s2 = q_r.rx_s1;

    // Microsecond enable from the system clock
    q_nxt.tick = (q_r.div == DIV_LAST);
    q_nxt.div  = q_nxt.tick ? '0 : q_r.div + DIV_W'(1);

    // Reset hold counter; ends the internal reset source
    // Counted before the bus so a restart in the same cycle wins
    if (q_r.hold_act & q_r.tick) begin
      if (q_r.hold_cnt == HOLD_LAST) begin
        q_nxt.hold_act = 1'b0;
      end else begin
        q_nxt.hold_cnt = q_r.hold_cnt + CNT_W'(1);
      end
    end

    // Bus slave: one wait cycle, then the access completes
    if ((req.read | req.write) & q_r.waitreq) begin
      q_nxt.waitreq = 1'b0;
      q_nxt.rdata   = req.read ? read_mux(q_r, req.address) : '0;
    end else begin
      q_nxt.waitreq = 1'b1;
    end

    if (bus_hit & req.write) begin
      unique case (req.address)
        ADDR_SYSCTL: begin
          q_nxt.power_stage_on_flag      = req.writedata[SYSCTL_POWER_STAGE_ON_FLAG_BIT];
          q_nxt.stop_req  = req.writedata[SYSCTL_STOP_BIT];
          q_nxt.sleep_req = req.writedata[SYSCTL_SLEEP_BIT];
        end
        ADDR_IRQFLAG: begin
          if (req.writedata[FLAG_WAKE_BIT]) q_nxt.wake_flag = 1'b0;
          if (req.writedata[FLAG_TOUT_BIT]) q_nxt.tout_flag = 1'b0;
        end
        ADDR_IRQMASK: q_nxt.wake_en = req.writedata[MASK_WAKE_BIT];
        ADDR_CMD: begin
          if (req.writedata[CMD_RESET_BIT]) begin
            q_nxt.hold_act = 1'b1;
            q_nxt.hold_cnt = '0;
          end
        end
        default: ;
      endcase
    end

    // Low-power mode selection from the control bits
    if (q_r.mode == MODE_NORMAL) begin
      if (q_r.sleep_req) begin
        q_nxt.mode = MODE_SLEEP;
      end else if (q_r.stop_req) begin
        q_nxt.mode = MODE_STOP;
      end
    end

    // Confirmation timer: restart on release, stop on flag or test mode
    if (line_rise) begin
      q_nxt.conf_run = ~q_r.tm_s2;
      q_nxt.conf_cnt = '0;
    end else if (q_r.conf_run) begin
      if (q_r.power_stage_on_flag) begin
        q_nxt.conf_run = 1'b0;
      end else if (q_r.tick) begin
        if (q_r.conf_cnt == CONF_LAST) begin
          q_nxt.conf_run  = 1'b0;
          q_nxt.tout_flag = 1'b1;
          q_nxt.mode      = MODE_SLEEP;
        end else begin
          q_nxt.conf_cnt = q_r.conf_cnt + CNT_W'(1);
        end
      end
    end
    if (q_r.tm_s2) begin
      q_nxt.conf_run = 1'b0;
    end

    // Wake edges; from sleep the system restarts through a reset
    if (wake_edge) begin
      q_nxt.wake_flag = 1'b1;
      if (q_r.mode == MODE_STOP) begin
        q_nxt.mode     = MODE_NORMAL;
        q_nxt.stop_req = 1'b0;
      end else if (q_r.mode == MODE_SLEEP) begin
        q_nxt.mode      = MODE_NORMAL;
        q_nxt.sleep_req = 1'b0;
        q_nxt.hold_act  = 1'b1;
        q_nxt.hold_cnt  = '0;
      end
    end

    // A low line from either side resets this die's control state
    if (!q_r.rl_s2) begin
      q_nxt.power_stage_on_flag      = 1'b0;
      q_nxt.stop_req  = 1'b0;
      q_nxt.sleep_req = 1'b0;
      q_nxt.conf_run  = 1'b0;
      q_nxt.mode      = MODE_NORMAL;
    end

    // Pin drivers; line is driven low only while a source is active
    q_nxt.rst_oe = q_nxt.hold_act;
    q_nxt.irq_oe = (q_nxt.wake_flag & q_nxt.wake_en) |
                   q_nxt.tout_flag;
    q_nxt.rx_out = q_r.tm_s2 ? 1'b1 : q_r.rx_s2;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q_r           <= '0;
      q_r.hold_act  <= 1'b1;
      q_r.rst_oe    <= 1'b1;
      q_r.mode      <= MODE_NORMAL;
      q_r.wake_en   <= RST_WAKE_EN;
      q_r.rx_out    <= 1'b1;
      // Receiver stages start recessive so rx does not dip after reset
      q_r.rx_s1     <= 1'b1;
      q_r.rx_s2     <= 1'b1;
      q_r.waitreq   <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign o_avs_readdata    = q_r.rdata;
  assign o_avs_waitrequest = q_r.waitreq;
  assign o_rst_line_o      = 1'b0;
  assign o_rst_line_oe     = q_r.rst_oe;
  assign o_irq_line_o      = 1'b0;
  assign o_irq_line_oe     = q_r.irq_oe;
  assign o_rx              = q_r.rx_out;
  assign o_mode            = q_r.mode;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_req_waits;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence s_one_beat;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence

  a_bus_one_wait: assert property (s_req_waits |=> s_one_beat)
    else $error("Bus answer not after exactly one wait cycle");

  a_source_drives_pin: assert property (
    q_r.hold_act |-> o_rst_line_oe)
    else $error("Reset source active but line not driven");

  a_hold_full_len: assert property (
    $fell(q_r.hold_act) |-> q_r.hold_cnt == HOLD_LAST)
    else $error("Reset hold released early");

  a_line_clears_flag: assert property (
    !q_r.rl_s2 |=> !q_r.power_stage_on_flag && q_r.mode == MODE_NORMAL)
    else $error("Low reset line did not clear control state");

  a_timeout_sleep: assert property (
    q_r.conf_run && q_r.tick && q_r.conf_cnt == CONF_LAST && !q_r.power_stage_on_flag &&
    !q_r.tm_s2 && q_r.rl_s2 && !line_rise && !wake_edge
    |=> q_r.mode == MODE_SLEEP && q_r.tout_flag ##1 o_irq_line_oe)
    else $error("Missing confirmation did not force sleep");

  a_test_no_timer: assert property (
    q_r.tm_s2 |=> !q_r.conf_run)
    else $error("Confirmation timer runs in test mode");

  a_test_rx_idle: assert property (
    q_r.tm_s2 && $past(q_r.tm_s2) |-> o_rx)
    else $error("Receiver output follows bus in test mode");

  a_wake_sets_flag: assert property (
    wake_edge |=> q_r.wake_flag)
    else $error("Wake edge lost");

  a_tout_irq_pin: assert property (
    q_r.tout_flag |-> o_irq_line_oe)
    else $error("Timeout flag not signalled on interrupt line");

  a_flag_stops_timer: assert property (
    q_r.conf_run && q_r.power_stage_on_flag && !line_rise |=> !q_r.conf_run)
    else $error("Confirmation timer kept running after flag set");

  a_release_restarts: assert property (
    line_rise && !q_r.tm_s2 |=> q_r.conf_run && q_r.conf_cnt == '0)
    else $error("Timer not restarted on reset release");

  a_sleep_bit_mode: assert property (
    q_r.mode == MODE_NORMAL && q_r.sleep_req && q_r.rl_s2 && !wake_edge
    |=> q_r.mode == MODE_SLEEP)
    else $error("Sleep bit did not select sleep mode");

  sequence s_sleep_wake;
    wake_edge && q_r.mode == MODE_SLEEP;
  endsequence
  sequence s_hold_restart;
    q_r.hold_act && o_rst_line_oe && q_r.mode == MODE_NORMAL;
  endsequence

  a_sleep_wake_hold: assert property (
    s_sleep_wake |=> s_hold_restart)
    else $error("Wake from sleep did not restart the reset hold");

  a_stop_wake_run: assert property (
    wake_edge && q_r.mode == MODE_STOP
    |=> q_r.mode == MODE_NORMAL && !q_r.stop_req)
    else $error("Wake edge did not leave stop mode");

  a_stop_bit_mode: assert property (
    q_r.mode == MODE_NORMAL && q_r.stop_req && !q_r.sleep_req &&
    !q_r.conf_run && q_r.rl_s2 && !wake_edge |=> q_r.mode == MODE_STOP)
    else $error("Stop bit did not select stop mode");

  a_timer_counts: assert property (
    q_r.conf_run && !q_r.power_stage_on_flag && q_r.tick && q_r.conf_cnt != CONF_LAST &&
    !line_rise |=> q_r.conf_cnt == $past(q_r.conf_cnt) + CNT_W'(1))
    else $error("Confirmation timer missed a tick");

  a_line_stops_timer: assert property (
    !q_r.rl_s2 |=> !q_r.conf_run)
    else $error("Low reset line left the timer running");

  a_test_forces_rx: assert property (
    $rose(q_r.tm_s2) |=> o_rx)
    else $error("Test mode did not idle the receiver output");

  a_hold_starts_zero: assert property (
    $rose(q_r.hold_act) |-> q_r.hold_cnt == '0)
    else $error("Reset hold started part way through its count");

endmodule : startup_supervisor

// *** shared/supervisor_pkg.sv ***
// Constants, types and state layout for the start-up supervisor
package supervisor_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 50;
  localparam int TICK_NS         = 1000;
  localparam int TICK_CYCLES     = TICK_NS / CLK_PERIOD_NS;
  localparam int RST_HOLD_MIN_US = 800;
  localparam int RST_HOLD_MAX_US = 1940;
  localparam int RST_HOLD_US     = 1250;
  localparam int CONF_TIMEOUT_MS = 80;
  localparam int CONF_TIMEOUT_US = CONF_TIMEOUT_MS * 1000;
  localparam int CNT_W           = 17;
  localparam int DIV_W           = 5;

  // ----------------------------------------------------------------------
  // Register map (byte addresses) and fields
  // ----------------------------------------------------------------------
  localparam logic [4:0] ADDR_SYSCTL  = 5'h00;
  localparam logic [4:0] ADDR_STATUS  = 5'h04;
  localparam logic [4:0] ADDR_IRQFLAG = 5'h08;
  localparam logic [4:0] ADDR_IRQMASK = 5'h0c;
  localparam logic [4:0] ADDR_CMD     = 5'h10;
  localparam int SYSCTL_POWER_STAGE_ON_FLAG_BIT   = 0;
  localparam int SYSCTL_STOP_BIT   = 1;
  localparam int SYSCTL_SLEEP_BIT  = 2;
  localparam int FLAG_WAKE_BIT     = 0;
  localparam int FLAG_TOUT_BIT     = 1;
  localparam int MASK_WAKE_BIT     = 0;
  localparam int CMD_RESET_BIT     = 0;
  localparam int STATUS_MODE_LSB   = 0;
  localparam int STATUS_RUN_BIT    = 3;
  localparam int STATUS_LINE_BIT   = 4;
  localparam int STATUS_TEST_BIT   = 5;
  localparam logic RST_WAKE_EN     = 1'b0;

  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b001,
    MODE_STOP   = 3'b010,
    MODE_SLEEP  = 3'b100
  } mode_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [4:0]  address;
    logic [31:0] writedata;
  } avs_req_t;

  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic             tick;
    logic [CNT_W-1:0] hold_cnt;
    logic             hold_act;
    logic [CNT_W-1:0] conf_cnt;
    logic             conf_run;
    mode_t            mode;
    logic             power_stage_on_flag;
    logic             stop_req;
    logic             sleep_req;
    logic             wake_flag;
    logic             tout_flag;
    logic             wake_en;
    logic             tm_s1;
    logic             tm_s2;
    logic             wk_s1;
    logic             wk_s2;
    logic             wk_s3;
    logic             rl_s1;
    logic             rl_s2;
    logic             rl_s3;
    logic             rx_s1;
    logic             rx_s2;
    logic             rx_out;
    logic             rst_oe;
    logic             irq_oe;
    logic             waitreq;
    logic [31:0]      rdata;
  } sup_state_t;

endpackage : supervisor_pkg

// *** tb/mcu_model.sv ***
// Microcontroller-side model: open-drain wires and external reset pull
module mcu_model (
  input  wire logic i_rst_oe,
  input  wire logic i_irq_oe,
  input  wire logic i_pull_rst,
  output logic      o_rst_wire,
  output logic      o_irq_wire,
  output logic      o_in_reset
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pull-ups win only while no party drives the wire low
  assign o_rst_wire = ~(i_rst_oe | i_pull_rst);
  assign o_irq_wire = ~i_irq_oe;
  // Core sits in its start-up state while the wire is low
  assign o_in_reset = ~o_rst_wire;
endmodule : mcu_model

// *** tb/startup_supervisor_reset_wake_tb.sv ***
// Self-checking bench for the start-up supervisor
module startup_supervisor_reset_wake_tb;
  import supervisor_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_n, rd, wr, wake, test, bus_rx, pull;
  logic [4:0]  addr;
  logic [31:0] wdata, rdata, d;
  logic        wreq, rst_oe, irq_oe, rx, rst_wire, irq_wire, in_rst;
  logic        rst_o, irq_o;
  logic [2:0]  mode;
  int          fail_count = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          n;

  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end

  // Short counts keep the run brief: hold 80 clocks, timeout 400 clocks
  startup_supervisor #(.HOLD_TICKS(4), .CONF_TICKS(20)) DUT (
    .i_clk(clk), .i_rst_n(rst_n), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_address(addr), .i_avs_writedata(wdata),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
    .i_rst_line_i(rst_wire), .o_rst_line_o(rst_o), .o_rst_line_oe(rst_oe),
    .o_irq_line_o(irq_o), .o_irq_line_oe(irq_oe), .i_wake_input_pin(wake),
    .i_test_select_pin(test), .i_bus_rx(bus_rx), .o_rx(rx), .o_mode(mode));

  mcu_model partner (
    .i_rst_oe(rst_oe), .i_irq_oe(irq_oe), .i_pull_rst(pull),
    .o_rst_wire(rst_wire), .o_irq_wire(irq_wire), .o_in_reset(in_rst));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task end_sim;
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end

  // Held until waitrequest is seen low at a rising edge, then released
  task bus(input logic w, input logic [4:0] a, input logic [31:0] v);
    rd <= ~w;
    wr <= w;
    addr <= a;
    wdata <= v;
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    d = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask : bus

  task idle(input int k);
    repeat (k) @(posedge clk);
  endtask : idle

  task wait_mode(input logic [2:0] m, input int lim);
    n = 0;
    while (mode !== m && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk(mode, m);
  endtask : wait_mode

  task wait_hold;
    n = 0;
    while (rst_oe === 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_hold

  task t_hold;
    chk(rst_wire, 1'b0);
    chk({rst_o, irq_o}, 32'h0);
    wait_hold();
    chk(n >= 80 && n <= 105, 1'b1);
    idle(2);
    chk(rst_wire, 1'b1);
    $display("test hold done");
  endtask : t_hold

  task t_confirm;
    bus(1'b1, ADDR_SYSCTL, 32'h1);
    idle(600);
    chk(mode, MODE_NORMAL);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(d[STATUS_RUN_BIT], 1'b0);
    bus(1'b1, 5'h14, 32'h6);
    bus(1'b0, ADDR_SYSCTL, 32'h0);
    chk(d, 32'h1);
    bus(1'b0, 5'h14, 32'h0);
    chk(d, 32'h0);
    $display("test confirm done");
  endtask : t_confirm

  task t_stop_wake;
    bus(1'b1, ADDR_IRQMASK, 32'h1);
    bus(1'b1, ADDR_SYSCTL, 32'h3);
    wait_mode(MODE_STOP, 20);
    wake <= 1'b1;
    wait_mode(MODE_NORMAL, 20);
    idle(2);
    chk(irq_wire, 1'b0);
    bus(1'b1, ADDR_IRQFLAG, 32'h1);
    idle(2);
    chk(irq_wire, 1'b1);
    bus(1'b1, ADDR_CMD, 32'h1);
    chk(rst_oe, 1'b1);
    wait_hold();
    chk(n >= 3 * TICK_CYCLES, 1'b1);
    $display("test stop wake done");
  endtask : t_stop_wake

  // Sleep exit restarts the hold; confirm again once it ends
  task wake_sleep(input logic v);
    wake <= v;
    wait_mode(MODE_NORMAL, 20);
    idle(1);
    chk(rst_oe, 1'b1);
    wait_hold();
    bus(1'b1, ADDR_SYSCTL, 32'h1);
    bus(1'b1, ADDR_IRQFLAG, 32'h3);
  endtask : wake_sleep

  task t_timeout;
    pull <= 1'b1;
    idle(5);
    chk(in_rst, 1'b1);
    pull <= 1'b0;
    bus(1'b0, ADDR_SYSCTL, 32'h0);
    chk(d, 32'h0);
    wait_mode(MODE_SLEEP, 1000);
    bus(1'b0, ADDR_IRQFLAG, 32'h0);
    chk(d[FLAG_TOUT_BIT], 1'b1);
    chk(irq_wire, 1'b0);
    wake_sleep(1'b0);
    bus(1'b1, ADDR_SYSCTL, 32'h5);
    wait_mode(MODE_SLEEP, 20);
    wake_sleep(1'b1);
    $display("test timeout done");
  endtask : t_timeout

  task t_test;
    test <= 1'b1;
    bus_rx <= 1'b0;
    idle(6);
    chk(rx, 1'b1);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(d[STATUS_TEST_BIT], 1'b1);
    pull <= 1'b1;
    idle(5);
    pull <= 1'b0;
    idle(600);
    chk(mode, MODE_NORMAL);
    test <= 1'b0;
    idle(6);
    chk(rx, 1'b0);
    bus_rx <= 1'b1;
    idle(6);
    chk(rx, 1'b1);
    $display("test mode done");
  endtask : t_test

  initial begin
    rst_n = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 5'h00;
    wdata = 32'h0;
    wake = 1'b0;
    test = 1'b0;
    bus_rx = 1'b1;
    pull = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_hold();
    t_confirm();
    t_stop_wake();
    t_timeout();
    t_test();
    end_sim();
  end
endmodule : startup_supervisor_reset_wake_tb
